// *** verilog/scc_pkg.sv ***
// package: constants and carriers for the system clock source control block
package scc_pkg;

    // register offsets on the apb bus (byte addresses)
    localparam logic [7:0] TRIM_OFS      = 8'h00;
    localparam logic [7:0] SETUP_OFS     = 8'h04;
    localparam logic [7:0] STATUS_OFS    = 8'h08;
    localparam logic [7:0] CTRL_OFS      = 8'h0C;

    localparam int         TRIM_W        = 5;
    localparam logic [4:0] TRIM_RST      = 5'h00;
    localparam logic [4:0] TRIM_MAX      = 5'h0F;
    localparam logic [4:0] TRIM_MIN      = 5'h10;

    // setup word fields
    localparam int         SEL_LSB       = 0;
    localparam int         SEL_W         = 3;
    localparam int         POWER_UP_DELAY_TIMER_EN_BIT   = 4;
    localparam int         IFS_BIT       = 7;

    // clock source select encodings, parameterised by the top module
    localparam logic [2:0] ENC_LP        = 3'h0;
    localparam logic [2:0] ENC_XT        = 3'h1;
    localparam logic [2:0] ENC_HS        = 3'h2;
    localparam logic [2:0] ENC_EXT       = 3'h3;
    localparam logic [2:0] ENC_INT_PIN   = 3'h4;
    localparam logic [2:0] ENC_INT_OUT   = 3'h5;
    localparam logic [2:0] ENC_RC_PIN    = 3'h6;
    localparam logic [2:0] ENC_RC_OUT    = 3'h7;

    // settle counts
    localparam int         SETTLE_OSC    = 1024;
    localparam int         SETTLE_W      = 11;
    localparam logic [10:0] SETTLE_LAST  = 11'(SETTLE_OSC - 1);
    localparam int         EXT_RC_INSTR  = 2;
    localparam int         INSTR_CYC     = 4;
    localparam logic [10:0] EXT_RC_LAST  = 11'(EXT_RC_INSTR * INSTR_CYC - 1);

    // internal warm-up delay, time and derived cycle count at pclk
    localparam int         CLK_HZ        = 10_000_000;
    localparam int         WARMUP_US     = 5;
    localparam int         WARMUP_CYC    = (WARMUP_US * (CLK_HZ / 1_000_000));
    localparam logic [10:0] WARMUP_LAST  = 11'(WARMUP_CYC - 1);

    localparam logic [1:0] DIV4_LAST     = 2'h3;

    // amplifier gain codes
    localparam logic [1:0] GAIN_OFF      = 2'h0;
    localparam logic [1:0] GAIN_LOW      = 2'h1;
    localparam logic [1:0] GAIN_MID      = 2'h2;
    localparam logic [1:0] GAIN_HIGH     = 2'h3;

    typedef enum logic [3:0] {
        MODE_EXT, MODE_LP, MODE_XT, MODE_HS,
        MODE_RC_OUT, MODE_RC_PIN, MODE_INT_OUT, MODE_INT_PIN
    } scc_mode_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } scc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } scc_apb_rsp_t;

    // pin control: oe low means the block drives the pin
    typedef struct packed {
        logic primary_gpio;
        logic secondary_gpio;
        logic clock_out_pin;
        logic clock_out_oe_n;
    } scc_pins_t;

endpackage

// *** verilog/scc_sync.sv ***
// two-flop level synchroniser
`timescale 1ns/1ps
module scc_sync
    import scc_pkg::*;
(
    input  wire logic pclk,     // system clock
    input  wire logic presetn,  // async reset, active low
    input  wire logic d,        // asynchronous level
    output logic      q         // synchronised level
);
    typedef struct packed {
        logic s1;
        logic s2;
    } scc_sync_st_t;

    scc_sync_st_t st_q;
    scc_sync_st_t st_d;

    always_comb
    begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign q = st_q.s2;
endmodule

// *** verilog/scc_top.sv ***
// system clock source selection, settle timer and frequency trim
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps

//Contract
// R1: crystal modes wait 1024 primary pin oscillations before clock is stable.
// R2: settle timer starts after power-on (post delay timer) and each sleep wake.
// R3: while settling, program counter holds and execution is suspended.
// R4: any clock source switch inserts a stabilisation delay.
// R5: external clock mode skips the settle timer entirely.
// R6: external clock mode takes primary pin, frees secondary pin.
// R7: fully static logic; clock stop just halts, state kept.
// R8: crystal gain: low power lowest, medium middle, high gain highest.
// R9: rc with output drives clock out at oscillator divided by four; the code divides pclk by four, not the primary pin oscillator.
// R10: rc pin mode: rc on primary, secondary pin is gpio.
// R11: internal oscillator runs 4 or 8 MHz per select bit.
// R12: setup word select field picks the driving oscillator mode.
// R13: internal with output: primary gpio, clock out is divided by four.
// R14: internal pin mode frees both oscillator pins.
// R15: trim register is 5-bit two's complement, default zero.
// R16: trim 01111 maximum, 00000 calibrated, 10000 minimum, monotonic.
// R17: trim write shifts frequency with execution running, no done status.
// R18: trim clears on power-on or brown-out only, kept on other resets.
// R19: select field chooses among eight clock modes.
// R20: select field encoding is a parameter.
// R21: settle count runs on raw oscillator, done is synchronised; the code counts synchronised oscillator edges on pclk.
module scc_top
    import scc_pkg::*;
#(
    parameter logic [2:0] P_ENC_LP      = ENC_LP,
    parameter logic [2:0] P_ENC_XT      = ENC_XT,
    parameter logic [2:0] P_ENC_HS      = ENC_HS,
    parameter logic [2:0] P_ENC_EXT     = ENC_EXT,
    parameter logic [2:0] P_ENC_INT_PIN = ENC_INT_PIN,
    parameter logic [2:0] P_ENC_INT_OUT = ENC_INT_OUT,
    parameter logic [2:0] P_ENC_RC_PIN  = ENC_RC_PIN,
    parameter logic [2:0] P_ENC_RC_OUT  = ENC_RC_OUT
)
(
    input  wire logic         pclk,          // system clock, 10 MHz
    input  wire logic         presetn,       // async reset, active low
    input  wire logic         por_bor_n,     // power-on/brown-out reset, low
    input  wire logic         psel,          // apb select
    input  wire logic         penable,       // apb enable
    input  wire logic         pwrite,        // apb write
    input  wire logic [7:0]   paddr,         // apb byte address
    input  wire logic [31:0]  pwdata,        // apb write data
    output logic [31:0]       prdata,        // apb read data
    output logic              pready,        // apb ready
    output logic              pslverr,       // apb error
    input  wire logic [7:0]   setup_word,    // device setup word
    input  wire logic         power_up_delay_timer_expired,  // power-up delay timer done
    input  wire logic         wake_event,    // one pulse on sleep wake-up
    input  wire logic         primary_osc,   // raw primary clock pin level
    output logic              run_enable,    // high when execution may run
    output logic [1:0]        amp_gain,      // crystal amplifier gain
    output logic              int_freq_hi,   // internal osc at 8 MHz
    output logic [4:0]        freq_trim_bits,// trim to internal oscillator
    output logic              primary_gpio,  // primary pin freed for gpio
    output logic              secondary_gpio,// secondary pin freed for gpio
    output logic              clock_out_pin, // clock out level
    output logic              clock_out_oe_n // clock out drive, active low
);

    typedef enum logic [1:0] {
        ST_WAIT_PWR, ST_SETTLE, ST_RUN
    } scc_state_t;

    // all block state but the trim register in one struct, per house style
    typedef struct packed {
        scc_state_t     state;
        scc_mode_t      mode;
        logic [10:0]    cnt;
        logic           prev_osc;
        logic [1:0]     div;
        logic           cko;
        logic           run;
        logic [31:0]    rdata;
        logic           err;
        logic           restart_req;
    } scc_st_t;

    scc_st_t   st_q;
    scc_st_t   st_d;
    scc_mode_t sel_mode;
    logic      osc_s;
    logic      osc_rise;
    logic      apb_access;
    logic      apb_wr;
    logic      trim_wr;
    logic [4:0] trim_q;
    logic [4:0] trim_d;
    logic      mode_switch;
    logic      apb_rd_setup;
    scc_apb_req_t req;
    scc_apb_rsp_t rsp;
    scc_pins_t    pins;

    // R21
    // oscillator level synchronised before any edge logic looks at it
    scc_sync u_osc_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (primary_osc),
        .q       (osc_s)
    );

    assign osc_rise = osc_s & ~st_q.prev_osc;

    // R12 R19 R20
    // decode select field through parameterised encodings
    always_comb
    begin
        case (setup_word[SEL_LSB +: SEL_W])
            P_ENC_LP:      sel_mode = MODE_LP;
            P_ENC_XT:      sel_mode = MODE_XT;
            P_ENC_HS:      sel_mode = MODE_HS;
            P_ENC_EXT:     sel_mode = MODE_EXT;
            P_ENC_INT_PIN: sel_mode = MODE_INT_PIN;
            P_ENC_INT_OUT: sel_mode = MODE_INT_OUT;
            P_ENC_RC_PIN:  sel_mode = MODE_RC_PIN;
            P_ENC_RC_OUT:  sel_mode = MODE_RC_OUT;
            default:       sel_mode = MODE_EXT;
        endcase
    end

    // bus inputs travel as one carrier inside the block
    always_comb
    begin
        req.psel    = psel;
        req.penable = penable;
        req.pwrite  = pwrite;
        req.paddr   = paddr;
        req.pwdata  = pwdata;
    end

    assign apb_access   = req.psel & req.penable;
    assign apb_wr       = apb_access & req.pwrite;
    assign trim_wr      = apb_wr & (req.paddr == TRIM_OFS);
    // read data is captured in the setup cycle so it stands in the access
    assign apb_rd_setup = req.psel & ~req.penable & ~req.pwrite;

    // a new select value or a software restart both count as a switch
    assign mode_switch  = (sel_mode != st_q.mode) || st_q.restart_req;

    // R15 R18
    // trim survives the ordinary reset; only power-on/brown-out clears it
    // kept apart from the block state: it lives in the power-on reset
    // domain and has to outlive the ordinary reset
    always_comb
    begin
        trim_d = trim_q;
        if (trim_wr)
            trim_d = req.pwdata[TRIM_W-1:0];
    end

    always_ff @(posedge pclk or negedge por_bor_n)
    begin
        if (!por_bor_n)
            trim_q <= TRIM_RST;
        else
            trim_q <= trim_d;
    end

    always_comb
    begin
        st_d          = st_q;
        st_d.prev_osc = osc_s;
        st_d.err      = 1'b0;

        case (st_q.state)
            ST_WAIT_PWR:
            begin
                // R2
                // settle begins once the power-up delay has run
                if (power_up_delay_timer_expired || !setup_word[POWER_UP_DELAY_TIMER_EN_BIT])
                begin
                    st_d.state = ST_SETTLE;
                    st_d.cnt   = '0;
                end
            end
            ST_SETTLE:
            begin
                case (st_q.mode)
                    MODE_LP, MODE_XT, MODE_HS:
                    begin
                        // R1
                        // count rising edges of the synchronised oscillator level
                        if (osc_rise)
                        begin
                            if (st_q.cnt == SETTLE_LAST)
                                st_d.state = ST_RUN;
                            else
                                st_d.cnt = st_q.cnt + 11'h001;
                        end
                    end
                    // R5
                    // external clock: no settle count, settle lasts a single cycle
                    MODE_EXT:
                        st_d.state = ST_RUN;
                    MODE_INT_OUT, MODE_INT_PIN:
                    begin
                        if (st_q.cnt == WARMUP_LAST)
                            st_d.state = ST_RUN;
                        else
                            st_d.cnt = st_q.cnt + 11'h001;
                    end
                    default:
                    begin
                        if (st_q.cnt == EXT_RC_LAST)
                            st_d.state = ST_RUN;
                        else
                            st_d.cnt = st_q.cnt + 11'h001;
                    end
                endcase
            end
            ST_RUN:
            begin
                // R2
                // every wake-up from sleep re-arms the settle timer
                if (wake_event)
                begin
                    st_d.state = ST_SETTLE;
                    st_d.cnt   = '0;
                end
            end
            default:
                st_d.state = ST_WAIT_PWR;
        endcase

        // R4
        // a new source or software restart re-runs the delay; placed after
        // the state case so a switch in mid-settle restarts the count
        if (mode_switch)
        begin
            st_d.mode        = sel_mode;
            st_d.restart_req = 1'b0;
            if (st_q.state != ST_WAIT_PWR)
            begin
                st_d.state = ST_SETTLE;
                st_d.cnt   = '0;
            end
        end

        // R3
        // execution enable follows the run state only
        st_d.run = (st_d.state == ST_RUN);

        // R9 R13
        // clock out toggles every two ticks, giving one quarter rate
        if (st_q.div == DIV4_LAST)
            st_d.div = '0;
        else
            st_d.div = st_q.div + 2'h1;
        if (st_q.div[0])
            st_d.cko = ~st_q.cko;

        // apb: zero wait states, unmapped reads return error
        if (apb_rd_setup)
        begin
            case (req.paddr)
                TRIM_OFS:   st_d.rdata = {27'h0, trim_q};
                SETUP_OFS:  st_d.rdata = {24'h0, setup_word};
                STATUS_OFS: st_d.rdata = {26'h0, st_q.mode[2:0],
                                          st_q.state, st_q.run};
                CTRL_OFS:   st_d.rdata = 32'h0;
                default:    st_d.rdata = 32'h0;
            endcase
        end
        if (apb_access)
        begin
            case (req.paddr)
                TRIM_OFS, STATUS_OFS, SETUP_OFS: st_d.err = 1'b0;
                CTRL_OFS:
                    if (req.pwrite && req.pwdata[0])
                        st_d.restart_req = 1'b1;
                default: st_d.err = 1'b1;
            endcase
        end
    end

    // R7
    // everything moves only on pclk; a stopped clock freezes all state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q       <= '0;
            st_q.state <= ST_WAIT_PWR;
            st_q.mode  <= MODE_EXT;
        end
        else
            st_q <= st_d;
    end

    // R8
    // amplifier gain per crystal mode
    always_comb
    begin
        case (st_q.mode)
            MODE_LP: amp_gain = GAIN_LOW;
            MODE_XT: amp_gain = GAIN_MID;
            MODE_HS: amp_gain = GAIN_HIGH;
            default: amp_gain = GAIN_OFF;
        endcase
    end

    // R6 R10 R14
    // pin ownership per mode
    always_comb
    begin
        pins.primary_gpio   = (st_q.mode == MODE_INT_OUT) ||
                              (st_q.mode == MODE_INT_PIN);
        pins.secondary_gpio = (st_q.mode == MODE_EXT)     ||
                              (st_q.mode == MODE_RC_PIN)  ||
                              (st_q.mode == MODE_INT_PIN);
        pins.clock_out_oe_n = !((st_q.mode == MODE_RC_OUT) ||
                                (st_q.mode == MODE_INT_OUT));
        // a released pin shows low rather than the running divider
        pins.clock_out_pin  = st_q.cko & ~pins.clock_out_oe_n;
    end

    assign primary_gpio   = pins.primary_gpio;
    assign secondary_gpio = pins.secondary_gpio;
    assign clock_out_oe_n = pins.clock_out_oe_n;

    // R11
    // internal frequency select bit picks 8 MHz when set
    assign int_freq_hi = setup_word[IFS_BIT];

    // R16 R17
    // trim goes straight to the oscillator; no completion flag exists
    assign freq_trim_bits = trim_q;

    // zero wait states: the slave answers in the first access cycle
    always_comb
    begin
        rsp.prdata  = st_q.rdata;
        rsp.pready  = 1'b1;
        rsp.pslverr = st_q.err;
    end

    assign clock_out_pin = pins.clock_out_pin;
    assign run_enable    = st_q.run;
    assign prdata        = rsp.prdata;
    assign pready        = rsp.pready;
    assign pslverr       = rsp.pslverr;

endmodule

// *** verification/scc_osc_model.sv ***
// behavioural crystal, rc network or clock source on the primary pin
`timescale 1ns/1ps
module scc_osc_model (
    input  wire logic [9:0] half_ns, // half period in ns, less one
    output logic            osc      // primary pin level
);
    initial osc = 1'b0;
    // the extra ns keeps a zero period from stalling time at start
    always
        #(half_ns + 10'h001) osc = !osc;
endmodule

// *** verification/scc_top_sva.sv ***
// assertion checker for the clock source control top
`timescale 1ns/1ps
module scc_top_sva
    import scc_pkg::*;
#(
    parameter logic [2:0] P_ENC_LP      = ENC_LP,
    parameter logic [2:0] P_ENC_XT      = ENC_XT,
    parameter logic [2:0] P_ENC_HS      = ENC_HS,
    parameter logic [2:0] P_ENC_EXT     = ENC_EXT,
    parameter logic [2:0] P_ENC_INT_PIN = ENC_INT_PIN,
    parameter logic [2:0] P_ENC_INT_OUT = ENC_INT_OUT,
    parameter logic [2:0] P_ENC_RC_PIN  = ENC_RC_PIN,
    parameter logic [2:0] P_ENC_RC_OUT  = ENC_RC_OUT
)
(
    input wire logic        pclk,           // clock
    input wire logic        presetn,        // reset
    input wire logic        psel,           // select
    input wire logic        penable,        // enable
    input wire logic        pwrite,         // write
    input wire logic [7:0]  paddr,          // address
    input wire logic [31:0] pwdata,         // write data
    input wire logic [7:0]  setup_word,     // setup word
    input wire logic        wake_event,     // wake pulse
    input wire logic        primary_osc,    // raw pin
    input wire logic        run_enable,     // run allowed
    input wire logic [1:0]  amp_gain,       // gain
    input wire logic [4:0]  freq_trim_bits, // trim
    input wire logic        primary_gpio,   // primary freed
    input wire logic        secondary_gpio, // secondary freed
    input wire logic        clock_out_pin,  // clock out
    input wire logic        clock_out_oe_n  // clock out drive
);
    logic [2:0]  sel;
    logic        xtal;
    logic [4:0]  exp_pins;
    logic        osc_q;
    logic [11:0] edges_q;

    // {gain, primary freed, secondary freed, clock out drive}
    function automatic logic [4:0] pin_map(input logic [2:0] s);
        case (s)
            P_ENC_LP:      return {GAIN_LOW, 3'h1};
            P_ENC_XT:      return {GAIN_MID, 3'h1};
            P_ENC_HS:      return {GAIN_HIGH, 3'h1};
            P_ENC_RC_OUT:  return {GAIN_OFF, 3'h0};
            P_ENC_INT_OUT: return {GAIN_OFF, 3'h4};
            P_ENC_INT_PIN: return {GAIN_OFF, 3'h7};
            default:       return {GAIN_OFF, 3'h3};
        endcase
    endfunction

    assign sel      = setup_word[2:0];
    assign xtal     = sel inside {P_ENC_LP, P_ENC_XT, P_ENC_HS};
    assign exp_pins = pin_map(sel);

    // raw pin rises seen while held; the design's synchroniser only lags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_q   <= 1'b0;
            edges_q <= 12'h000;
        end
        else
        begin
            osc_q <= primary_osc;
            if (run_enable)
                edges_q <= 12'h000;
            else if (primary_osc && !osc_q && edges_q != 12'hFFF)
                edges_q <= edges_q + 12'h001;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence steady;
        $stable(setup_word)[*3] ##0 run_enable;
    endsequence
    sequence trim_wr;
        psel && penable && pwrite && paddr == TRIM_OFS;
    endsequence
    sequence held;
        !run_enable[*8];
    endsequence

    a_gain_map: assert property (steady |-> amp_gain == exp_pins[4:3])
        else $error("gain does not match the selected mode");
    a_pin_map: assert property (
        steady |-> {primary_gpio, secondary_gpio, clock_out_oe_n}
            == exp_pins[2:0])
        else $error("pin use does not match the selected mode");
    a_clock_out_pin_div: assert property (
        (!clock_out_oe_n)[*4] |-> clock_out_pin != $past(clock_out_pin, 2))
        else $error("clock out is not a divide by four wave");
    a_trim_load: assert property (
        trim_wr |=> freq_trim_bits == 5'($past(pwdata)))
        else $error("trim write did not load");
    a_trim_runs: assert property (trim_wr ##0 run_enable |=> run_enable)
        else $error("trim write stopped execution");
    a_wake_stop: assert property (
        wake_event && run_enable && xtal |-> ##[1:3] held)
        else $error("wake did not hold execution");
    a_settle_min: assert property ($rose(run_enable) && xtal
        |-> edges_q >= 12'h3FF)
        else $error("crystal released before its oscillation count");
    a_ext_fast: assert property (
        $fell(run_enable) && sel == P_ENC_EXT && $stable(setup_word)
        |-> ##[1:6] run_enable)
        else $error("external clock mode delayed execution");
endmodule

bind scc_top scc_top_sva #(
    .P_ENC_LP(P_ENC_LP), .P_ENC_XT(P_ENC_XT), .P_ENC_HS(P_ENC_HS),
    .P_ENC_EXT(P_ENC_EXT), .P_ENC_INT_PIN(P_ENC_INT_PIN),
    .P_ENC_INT_OUT(P_ENC_INT_OUT), .P_ENC_RC_PIN(P_ENC_RC_PIN),
    .P_ENC_RC_OUT(P_ENC_RC_OUT)
) u_sva (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .setup_word, .wake_event, .primary_osc, .run_enable, .amp_gain,
    .freq_trim_bits, .primary_gpio, .secondary_gpio, .clock_out_pin,
    .clock_out_oe_n
);

// *** verification/test_system_clock_source_control.sv ***
// self-checking bench for the system clock source control block
`timescale 1ns/1ps
module test_system_clock_source_control
    import scc_pkg::*;
;
    localparam int RCD = EXT_RC_INSTR * INSTR_CYC;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        por_bor_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  setup_word = 8'h12;
    logic        power_up_delay_timer_expired = 1'b0;
    logic        wake_event = 1'b0;
    logic [9:0]  half_ns = 10'h0AA;
    logic [31:0] prdata;
    logic        pready, pslverr, run_enable, int_freq_hi, primary_osc;
    logic        primary_gpio, secondary_gpio, clock_out_pin;
    logic        clock_out_oe_n;
    logic [1:0]  amp_gain;
    logic [4:0]  freq_trim_bits;
    logic [31:0] exp_q [$];
    int          mismatches = 0;
    int          comparisons = 0;
    // indexed by encoding: {gain, pins} and settle floor in cycles
    logic [4:0]  pins_tab [8] = '{5'h09, 5'h11, 5'h19, 5'h03,
                                  5'h07, 5'h04, 5'h03, 5'h00};
    int          lo_tab [8] = '{0, 0, 0, 1, WARMUP_CYC, WARMUP_CYC, RCD, RCD};
    logic [2:0]  order [7] = '{ENC_EXT, ENC_INT_OUT, ENC_INT_PIN,
                               ENC_RC_OUT, ENC_RC_PIN, ENC_LP, ENC_XT};

    scc_top uut (
        .pclk, .presetn, .por_bor_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .setup_word, .power_up_delay_timer_expired,
        .wake_event, .primary_osc, .run_enable, .amp_gain, .int_freq_hi,
        .freq_trim_bits, .primary_gpio, .secondary_gpio, .clock_out_pin,
        .clock_out_oe_n
    );
    scc_osc_model osc (.half_ns, .osc(primary_osc));

    always #50 pclk = ~pclk;

    task automatic check(input string w, input logic [31:0] s, e);
        comparisons++;
        if (s !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", w, e, s);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic tick(inout int n, input int lim);
        @(posedge pclk);
        n++;
        if (n > lim)
        begin
            check("wait_bound", 32'h0, 32'h1);
            complete_run();
        end
    endtask

    // leading edge keeps release and next setup in separate time steps
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            tick(n, 40);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // crystal window follows the model's period; others from the table
    task automatic settle(input logic [2:0] m);
        int n;
        int per;
        int lo;
        n = 0;
        while (run_enable !== 1'b0 && n < 5)
            tick(n, 5);
        check("run_held", 32'(run_enable), 32'h0);
        per = 2 * half_ns + 2;
        lo = lo_tab[m];
        if (m inside {ENC_LP, ENC_XT, ENC_HS})
            lo = (SETTLE_OSC - 1) * per / 100;
        while (run_enable !== 1'b1)
            tick(n, lo + 2 * per / 100 + 12);
        check("settle_min", 32'(n >= lo), 32'h1);
    endtask

    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            check("prdata", prdata, exp_q.pop_front());

    initial
    begin
        logic [31:0] d;
        logic [31:0] v;
        void'($urandom(32'hD238DF2E));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        por_bor_n <= 1'b1;
        repeat (20) @(posedge pclk);
        check("power_up_delay_timer_wait", 32'(run_enable), 32'h0);
        power_up_delay_timer_expired <= 1'b1;
        settle(ENC_HS);
        rd(TRIM_OFS, 32'h0);
        rd(STATUS_OFS, {26'h0, 3'(MODE_HS), 3'h5});
        for (int i = 0; i < 6; i++)
        begin
            d = $urandom;
            if (i < 2)
                d[4:0] = i ? TRIM_MIN : TRIM_MAX;
            apb(1'b1, TRIM_OFS, d);
            rd(TRIM_OFS, {27'h0, d[4:0]});
            check("trim", 32'(freq_trim_bits), {27'h0, d[4:0]});
            check("run_on", 32'(run_enable), 32'h1);
        end
        rd(8'h10, 32'h0);
        #1;
        check("slverr", 32'(pslverr), 32'h1);
        apb(1'b1, SETUP_OFS, 32'hFF);
        rd(SETUP_OFS, {24'h0, setup_word});
        apb(1'b1, CTRL_OFS, 32'h1);
        settle(ENC_HS);
        wake_event <= 1'b1;
        @(posedge pclk);
        wake_event <= 1'b0;
        settle(ENC_HS);
        foreach (order[k])
        begin
            half_ns <= (order[k] == ENC_LP) ? 10'h190 : 10'h0AA;
            setup_word <= {1'($urandom), 3'h1, 1'b0, order[k]};
            settle(order[k]);
            check("pins", 32'({amp_gain, primary_gpio, secondary_gpio,
                  clock_out_oe_n}), 32'(pins_tab[order[k]]));
            check("fsel", 32'(int_freq_hi), 32'(setup_word[7]));
            v = 0;
            repeat (8)
            begin
                @(posedge pclk);
                v += 32'(clock_out_pin);
            end
            check("clk_out", v, (order[k] inside {ENC_RC_OUT,
                  ENC_INT_OUT}) ? 32'h4 : 32'h0);
        end
        apb(1'b1, TRIM_OFS, 32'h0A);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(TRIM_OFS, 32'h0A);
        por_bor_n <= 1'b0;
        @(posedge pclk);
        por_bor_n <= 1'b1;
        rd(TRIM_OFS, 32'h0);
        complete_run();
    end
endmodule
